// [hdl/pad_state_control.sv]
/*
 * pad state control: decides drive, float, hold and input gating of all
 * port pads, the usb pads and the oscillator pads per cpu state.
 * assumes the low-power controller and software requests arrive on this
 * clock; pin inputs are asynchronous and synchronised in each pad slice.
 */
// Overview of operation
// [RULE1] while reset is held every pad floats; just after release digital pads float with input on.
// [RULE2] analog-shared pads float with input off after release until software enables digital input.
// [RULE3] the two sub-oscillator port pads float after release and feed zero to the core.
// [RULE4] in sleep, and in stop without float select, each pad keeps its previous drive.
// [RULE5] in stop with float select, each pad floats and feeds zero to the core.
// [RULE6] in that float state an interrupt-capable pad with its interrupt enabled still passes input.
// [RULE7] usb pads hold state with input on in sleep and hold state in stop regardless of float.
// [RULE8] in stop the oscillator input pads float or take input, outputs drive high or take input.
// [RULE9] sub-oscillator pads used as ports keep input off during and after reset.
// [RULE10] in serial write mode all port pads float with input on.
// [RULE11] a gated input disconnects the pin and presents a constant zero to the core.
// [RULE12] a held pad still follows a running peripheral; a port pad keeps its value.
// [RULE13] float select is sampled on stop entry and applied to all port pads in one cycle.
module pad_state_control
  import pad_state_pkg::*;
#(
  parameter int unsigned          N_PADS     = 16,
  parameter logic [N_PADS-1:0]    ANALOG_MSK = 16'h0f00,
  parameter logic [N_PADS-1:0]    SUBOSC_MSK = 16'h0003,
  parameter logic [N_PADS-1:0]    INTCAP_MSK = 16'hf0f0
)(
  // clock and reset
  input  wire logic              clock,
  input  wire logic              rst,
  // cpu state requests
  input  wire logic              init_done,
  input  wire logic              serial_write_mode,
  input  wire logic              sleep_req,
  input  wire logic              stop_req,
  input  wire logic              wake,
  input  wire logic              stop_output_float_select,
  // software configuration
  input  wire logic [N_PADS-1:0] ana_dig_en,
  input  wire logic [N_PADS-1:0] int_en,
  input  wire logic              sub_osc_port_sel,
  input  wire logic              main_osc_running,
  input  wire logic              sub_osc_running,
  // drive sources
  input  wire drive_s [N_PADS-1:0]   periph,
  input  wire drive_s [N_PADS-1:0]   port,
  input  wire drive_s [USB_PADS-1:0] usb_drive,
  // general pads
  input  wire logic [N_PADS-1:0] pad_in,
  output logic [N_PADS-1:0]      pad_out,
  output logic [N_PADS-1:0]      pad_oe,
  output logic [N_PADS-1:0]      core_in,
  // usb pads, bit 0 usb_dplus_pad, bit 1 usb_dminus_pad
  input  wire logic [USB_PADS-1:0] usb_in,
  output logic [USB_PADS-1:0]      usb_out,
  output logic [USB_PADS-1:0]      usb_oe,
  output logic [USB_PADS-1:0]      usb_core_in,
  // oscillator pads
  output logic                   main_osc_in_en,
  output logic                   main_osc_out_high,
  output logic                   sub_osc_in_en,
  output logic                   sub_osc_out_high
);

  ctl_state_s st_ff;
  ctl_state_s nxt_st;
  pad_mode_e  gen_mode;
  pad_mode_e  usb_mode;

  // cpu state sequencing and oscillator pad control
  always_comb begin
    nxt_st = st_ff;
    case (st_ff.state)
      st_init: begin
        if (serial_write_mode) begin
          nxt_st.state = st_serial;
        end else if (init_done) begin
          nxt_st.state = st_run;
        end
      end
      st_run: begin
        if (stop_req) begin
          nxt_st.state     = st_stop;
          nxt_st.float_sel = stop_output_float_select; // RULE13
        end else if (sleep_req) begin
          nxt_st.state = st_sleep;
        end
      end
      st_sleep, st_stop: begin
        if (wake) begin
          nxt_st.state = st_run;
        end
      end
      st_serial: nxt_st.state = st_serial; // left only through reset
      default:   nxt_st.state = st_init;
    endcase
    // oscillator pads: in stop a halted oscillator parks its output high, the sub one only when not used as a port
    if (nxt_st.state == st_stop) begin
      nxt_st.main_in_en    = main_osc_running; // RULE8
      nxt_st.main_out_high = ~main_osc_running;
      nxt_st.sub_in_en     = sub_osc_running & ~sub_osc_port_sel;
      nxt_st.sub_out_high  = ~sub_osc_running & ~sub_osc_port_sel;
    end else begin
      nxt_st.main_in_en    = 1'b1;
      nxt_st.main_out_high = 1'b0;
      nxt_st.sub_in_en     = 1'b0; // RULE9
      nxt_st.sub_out_high  = 1'b0;
    end
  end

  // controller register
  always_ff @(posedge clock) begin
    if (rst) begin
      st_ff <= '{state: st_init, float_sel: 1'b0, main_in_en: 1'b1,
                 main_out_high: 1'b0, sub_in_en: 1'b0, sub_out_high: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // mode per pad group; one shared mode makes the float apply in one cycle
  always_comb begin
    gen_mode = pm_run;
    usb_mode = pm_run;
    if (rst) begin
      gen_mode = pm_reset; // RULE1
      usb_mode = pm_reset;
    end else begin
      case (st_ff.state)
        st_init:   gen_mode = pm_init;
        st_run:    gen_mode = pm_run;
        st_sleep:  gen_mode = pm_hold; // RULE4
        st_stop:   gen_mode = st_ff.float_sel ? pm_float : pm_hold; // RULE5 RULE13
        st_serial: gen_mode = pm_serial; // RULE10
        default:   gen_mode = pm_init;
      endcase
      // usb pads never float in stop
      usb_mode = (gen_mode == pm_float) ? pm_hold : gen_mode; // RULE7
    end
  end

  // general port pads
  for (genvar i = 0; i < N_PADS; i++) begin : g_pad
    pad_slice u_pad (
      .clock      (clock),
      .rst        (rst),
      .mode       (gen_mode),
      .is_analog  (ANALOG_MSK[i]),
      .is_subosc  (SUBOSC_MSK[i]),
      .is_intcap  (INTCAP_MSK[i]),
      .ana_dig_en (ana_dig_en[i]),
      .int_en     (int_en[i]),
      .periph     (periph[i]),
      .port       (port[i]),
      .pin_in     (pad_in[i]),
      .pin_out    (pad_out[i]),
      .pin_oe     (pad_oe[i]),
      .core_in    (core_in[i])
    );
  end

  // usb differential pads, driven only by the usb function
  for (genvar u = 0; u < USB_PADS; u++) begin : g_usb
    pad_slice u_usb (
      .clock      (clock),
      .rst        (rst),
      .mode       (usb_mode),
      .is_analog  (1'b0),
      .is_subosc  (1'b0),
      .is_intcap  (1'b0),
      .ana_dig_en (1'b0),
      .int_en     (1'b0),
      .periph     (usb_drive[u]),
      .port       (usb_drive[u]),
      .pin_in     (usb_in[u]),
      .pin_out    (usb_out[u]),
      .pin_oe     (usb_oe[u]),
      .core_in    (usb_core_in[u])
    );
  end

  assign main_osc_in_en    = st_ff.main_in_en;
  assign main_osc_out_high = st_ff.main_out_high;
  assign sub_osc_in_en     = st_ff.sub_in_en;
  assign sub_osc_out_high  = st_ff.sub_out_high;

  // checks on the pad behaviour
  sequence seq_stop_entry;
    st_ff.state == st_run && stop_req;
  endsequence

  sequence seq_float_applied;
    ##1 (st_ff.state == st_stop) ##1 (pad_oe == '0);
  endsequence

  AST_RESET_FLOAT: assert property (@(posedge clock) // RULE1
    rst |=> (pad_oe == '0 && usb_oe == '0))
    else $error("pad driving after reset");

  AST_INIT_ANALOG: assert property (@(posedge clock) disable iff (rst) // RULE2
    st_ff.state == st_init |=> (core_in & ANALOG_MSK) == '0 && pad_oe == '0)
    else $error("analog pad input open after release");

  AST_INIT_SUBOSC: assert property (@(posedge clock) disable iff (rst) // RULE3
    st_ff.state == st_init |=> (core_in & SUBOSC_MSK) == '0 && sub_osc_in_en == 1'b0)
    else $error("sub-oscillator pad input not tied low");

  AST_HOLD_PORT: assert property (@(posedge clock) disable iff (rst) // RULE4
    (st_ff.state == st_sleep || (st_ff.state == st_stop && !st_ff.float_sel))
    |=> ((pad_out ^ $past(pad_out)) & ~$past(periph_active_vec(periph))) == '0)
    else $error("port pad changed while holding");

  AST_STOP_FLOAT: assert property (@(posedge clock) disable iff (rst) // RULE5
    (st_ff.state == st_stop && st_ff.float_sel)
    |=> pad_oe == '0 && (core_in & ~$past(int_en & INTCAP_MSK)) == '0)
    else $error("pad not floated in stop with float select");

  // each usb pad is judged on its own drive; an idle one must not move at all
  AST_USB_HOLD: assert property (@(posedge clock) disable iff (rst) // RULE7
    (st_ff.state == st_stop)
    |=> (((usb_oe ^ $past(usb_oe)) | (usb_out ^ $past(usb_out)))
         & ~$past(usb_active_vec(usb_drive))) == '0)
    else $error("usb pad released in stop");

  AST_OSC_STOP: assert property (@(posedge clock) disable iff (rst) // RULE8
    (st_ff.state == st_run && stop_req)
    |=> main_osc_out_high == !$past(main_osc_running)
        && main_osc_in_en == $past(main_osc_running))
    else $error("main oscillator pad wrong in stop");

  AST_SERIAL_FLOAT: assert property (@(posedge clock) disable iff (rst) // RULE10
    st_ff.state == st_serial |=> pad_oe == '0)
    else $error("pad driving in serial write mode");

  AST_FLOAT_SAMPLE: assert property (@(posedge clock) disable iff (rst) // RULE13
    seq_stop_entry ##0 stop_output_float_select |-> seq_float_applied)
    else $error("float select not applied on stop entry");

  // gathers the active bits of a drive vector; passed as an argument so the
  // checks see its sampled value, not one that a same-edge update changed
  function automatic logic [N_PADS-1:0] periph_active_vec(input drive_s [N_PADS-1:0] d);
    logic [N_PADS-1:0] v;
    v = '0;
    for (int k = 0; k < N_PADS; k++) begin
      v[k] = d[k].active;
    end
    return v;
  endfunction

  // same gathering for the usb drive vector
  function automatic logic [USB_PADS-1:0] usb_active_vec(input drive_s [USB_PADS-1:0] d);
    logic [USB_PADS-1:0] v;
    v = '0;
    for (int k = 0; k < USB_PADS; k++) begin
      v[k] = d[k].active;
    end
    return v;
  endfunction

endmodule // pad_state_control

// [hdl/pad_state_pkg.sv]
/*
 * shared types and constants for the pad state controller.
 * assumes one 100 mhz system clock and a synchronous active-high reset.
 */
package pad_state_pkg;

  // clock period, kept for anyone deriving counts from it
  localparam int unsigned CLK_PERIOD_NS = 10;

  // reset values of pad outputs and core-side inputs
  localparam logic PAD_OUT_RST = 1'b0;
  localparam logic PAD_OE_RST  = 1'b0;
  localparam logic CORE_IN_RST = 1'b0;

  // number of usb differential pads
  localparam int unsigned USB_PADS = 2;

  // cpu state as seen by the pads
  typedef enum logic [2:0] {
    st_init,
    st_run,
    st_sleep,
    st_stop,
    st_serial
  } cpu_state_e;

  // per-pad behaviour selected by the controller
  typedef enum logic [2:0] {
    pm_reset,
    pm_init,
    pm_run,
    pm_hold,
    pm_float,
    pm_serial
  } pad_mode_e;

  // per-pad registered state
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic out;
    logic oe;
    logic cin;
  } pad_ctl_s;

  // controller registered state
  typedef struct packed {
    cpu_state_e state;
    logic       float_sel;
    logic       main_in_en;
    logic       main_out_high;
    logic       sub_in_en;
    logic       sub_out_high;
  } ctl_state_s;

  // peripheral or port drive for one pad
  typedef struct packed {
    logic active;
    logic out;
    logic oe;
  } drive_s;

endpackage

// [hdl/pad_slice.sv]
/*
 * one pad's output driver and input gate, registered.
 * assumes the mode comes from logic on the same clock; the pin input
 * is asynchronous and is synchronised here before anything reads it.
 */
module pad_slice
  import pad_state_pkg::*;
(
  // clock and reset
  input  wire logic      clock,
  input  wire logic      rst,
  // mode and pad class
  input  wire pad_mode_e mode,
  input  wire logic      is_analog,
  input  wire logic      is_subosc,
  input  wire logic      is_intcap,
  input  wire logic      ana_dig_en,
  input  wire logic      int_en,
  // drive sources
  input  wire drive_s    periph,
  input  wire drive_s    port,
  // pin side
  input  wire logic      pin_in,
  output logic           pin_out,
  output logic           pin_oe,
  // core side
  output logic           core_in
);

  pad_ctl_s st_ff;
  pad_ctl_s nxt_st;

  // next pad state from the mode
  always_comb begin
    nxt_st       = st_ff;
    nxt_st.sync1 = pin_in;
    nxt_st.sync2 = st_ff.sync1;
    case (mode)
      pm_reset: begin
        nxt_st.out = PAD_OUT_RST; // RULE1
        nxt_st.oe  = PAD_OE_RST;
        nxt_st.cin = CORE_IN_RST;
      end
      pm_init: begin
        nxt_st.oe  = 1'b0; // RULE1
        // analog and sub-oscillator pads keep the gate closed, tied low
        nxt_st.cin = (is_analog | is_subosc) ? 1'b0 : st_ff.sync2; // RULE2 RULE3 RULE9 RULE11
      end
      pm_run: begin
        nxt_st.out = periph.active ? periph.out : port.out;
        nxt_st.oe  = periph.active ? periph.oe : port.oe;
        nxt_st.cin = (is_analog & ~ana_dig_en) ? 1'b0 : st_ff.sync2; // RULE2
      end
      pm_hold: begin
        // a running peripheral keeps steering; a port pad freezes
        if (periph.active) begin
          nxt_st.out = periph.out; // RULE12
          nxt_st.oe  = periph.oe;
        end
        nxt_st.cin = (is_analog & ~ana_dig_en) ? 1'b0 : st_ff.sync2; // RULE4
      end
      pm_float: begin
        nxt_st.oe  = 1'b0; // RULE5
        nxt_st.cin = (is_intcap & int_en) ? st_ff.sync2 : 1'b0; // RULE6 RULE11
      end
      pm_serial: begin
        nxt_st.oe  = 1'b0; // RULE10
        nxt_st.cin = st_ff.sync2;
      end
      default: begin
        nxt_st.oe  = 1'b0;
        nxt_st.cin = 1'b0;
      end
    endcase
  end

  // state register
  always_ff @(posedge clock) begin
    if (rst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pin_out = st_ff.out;
  assign pin_oe  = st_ff.oe;
  assign core_in = st_ff.cin;

endmodule // pad_slice

// [dv/board_model.sv]
/*
 * board circuitry on the port and usb pins of the pad state controller.
 * assumes the bench sets the level each board net settles to when released.
 */
module board_model
  import pad_state_pkg::*;
#(
  parameter int unsigned N = 16
)(
  // levels the board presents on released pins
  input  wire logic [N-1:0]        board_lvl,
  input  wire logic [USB_PADS-1:0] usb_lvl,
  // device drivers
  input  wire logic [N-1:0]        pad_out,
  input  wire logic [N-1:0]        pad_oe,
  input  wire logic [USB_PADS-1:0] usb_out,
  input  wire logic [USB_PADS-1:0] usb_oe,
  // resolved pin levels seen by the device
  output logic [N-1:0]             pad_in,
  output logic [USB_PADS-1:0]      usb_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // a driving device wins; a released pin shows the board level, never a stale drive
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & board_lvl);
  assign usb_in = (usb_oe & usb_out) | (~usb_oe & usb_lvl);
endmodule // board_model

// [dv/testbench.sv]
/*
 * self-checking bench for pad_state_control with a board model on its pins.
 * assumes the design package and the board model are compiled first.
 */
module testbench import pad_state_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;

  localparam logic [15:0] ANA  = 16'h0f00;
  localparam logic [15:0] SUB  = 16'h0003;
  localparam logic [15:0] ICAP = 16'hf0f0;

  logic clock, rst, init_done, serial_write_mode, sleep_req, stop_req, wake;
  logic stop_output_float_select, sub_osc_port_sel, main_osc_running, sub_osc_running;
  logic [15:0] ana_dig_en, int_en, pad_in, pad_out, pad_oe, core_in, board;
  drive_s [15:0] periph, port;
  drive_s [1:0]  usb_drive;
  logic [1:0]  usb_in, usb_out, usb_oe, usb_core_in, usb_board;
  logic main_osc_in_en, main_osc_out_high, sub_osc_in_en, sub_osc_out_high;
  logic [31:0] held, exp;
  logic        fs, mr;
  int          failures, n_tests;

  pad_state_control #(.N_PADS(16), .ANALOG_MSK(ANA), .SUBOSC_MSK(SUB), .INTCAP_MSK(ICAP)) dut (
    .clock, .rst, .init_done, .serial_write_mode, .sleep_req, .stop_req, .wake,
    .stop_output_float_select, .ana_dig_en, .int_en, .sub_osc_port_sel,
    .main_osc_running, .sub_osc_running, .periph, .port, .usb_drive,
    .pad_in, .pad_out, .pad_oe, .core_in, .usb_in, .usb_out, .usb_oe, .usb_core_in,
    .main_osc_in_en, .main_osc_out_high, .sub_osc_in_en, .sub_osc_out_high);

  board_model #(.N(16)) pins (.board_lvl(board), .usb_lvl(usb_board), .pad_out, .pad_oe,
    .usb_out, .usb_oe, .pad_in, .usb_in);

  // 100 mhz clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] want, input string what);
    n_tests++;
    if (got !== want) begin
      failures++;
      $display("[ERR] %0t %s got %h want %h", $time, what, got, want);
    end
  endtask

  task automatic step(input int n);
    repeat (n) @(posedge clock);
  endtask

  // long enough for the state, pad register and the two-stage input sync
  task automatic settle();
    step(5);
    #2;
  endtask

  task automatic results();
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // one-cycle request: 0 init done, 1 sleep, 2 stop, 3 wake
  task automatic pulse(input int k);
    @(posedge clock);
    case (k)
      0: init_done <= 1'b1;
      1: sleep_req <= 1'b1;
      2: stop_req <= 1'b1;
      default: wake <= 1'b1;
    endcase
    @(posedge clock);
    {init_done, sleep_req, stop_req, wake} <= 4'h0;
  endtask

  // new drive values; with keep the peripheral active flags stay so held and following pads stay apart
  task automatic shuffle(input logic keep);
    for (int i = 0; i < 16; i++) begin
      periph[i] <= {keep ? periph[i].active : 1'($urandom), 2'($urandom)};
      port[i] <= 3'($urandom);
    end
    usb_drive <= 6'($urandom);
  endtask

  task automatic do_reset();
    @(posedge clock);
    rst <= 1'b1;
    step(3);
    #2;
    chk(pad_oe, '0, "oe in reset");
    chk(core_in, '0, "core in reset");
    @(posedge clock);
    rst <= 1'b0;
  endtask

  // expected {out, oe}: a running peripheral steers, else port or held value
  function automatic logic [31:0] drive_now(input logic [31:0] h, input logic use_h);
    logic [15:0] o, e;
    for (int i = 0; i < 16; i++) begin
      if (periph[i].active) {o[i], e[i]} = {periph[i].out, periph[i].oe};
      else if (use_h) {o[i], e[i]} = {h[16+i], h[i]};
      else {o[i], e[i]} = {port[i].out, port[i].oe};
    end
    return {o, e};
  endfunction

  // main sequence
  initial begin
    {rst, init_done, serial_write_mode, sleep_req, stop_req, wake} = 6'h20;
    {stop_output_float_select, sub_osc_port_sel, main_osc_running, sub_osc_running} = 4'h0;
    {ana_dig_en, int_en, board, usb_board} = '0;
    {periph, port, usb_drive} = '0;
    failures = 0;
    n_tests = 0;
    void'($urandom(32'h5368));
    for (int r = 0; r < 4; r++) begin
      fs = 1'(r);
      mr = 1'(r >> 1);
      board <= 16'($urandom);
      usb_board <= 2'($urandom);
      ana_dig_en <= 16'($urandom);
      int_en <= 16'($urandom);
      sub_osc_port_sel <= fs;
      main_osc_running <= mr;
      sub_osc_running <= ~mr;
      stop_output_float_select <= fs;
      shuffle(1'b0);
      do_reset();
      settle();
      chk(pad_oe, '0, "init oe");
      chk(core_in & ~(ANA | SUB), board & ~(ANA | SUB), "init in");
      // analog pads stay gated in init whatever software has prepared
      chk(core_in & ANA, '0, "analog in");
      chk(core_in & SUB, '0, "subosc in");
      chk(16'(usb_oe), '0, "usb init oe");
      chk(16'({main_osc_in_en, main_osc_out_high, sub_osc_in_en, sub_osc_out_high}),
          16'h0008, "osc init");
      pulse(0);
      settle();
      held = drive_now('0, 1'b0);
      chk(pad_oe, held[15:0], "run oe");
      chk(pad_out & held[15:0], held[31:16] & held[15:0], "run out");
      // in run the software enable opens analog pads; the pin level may be our own drive
      chk(core_in, pad_in & (~ANA | ana_dig_en), "run in");
      pulse(1);
      step(2);
      shuffle(1'b1);
      settle();
      exp = drive_now(held, 1'b1);
      chk(pad_oe, exp[15:0], "sleep oe");
      chk(pad_out & exp[15:0], exp[31:16] & exp[15:0], "sleep out");
      chk(16'(usb_core_in), 16'(usb_in), "usb sleep");
      pulse(3);
      settle();
      held = drive_now('0, 1'b0);
      pulse(2);
      // flipping the select after entry must change nothing
      stop_output_float_select <= ~fs;
      step(2);
      #2;
      if (fs) chk(pad_oe, '0, "float edge");
      step(1);
      shuffle(1'b1);
      settle();
      exp = drive_now(held, 1'b1);
      if (fs) begin
        chk(pad_oe, '0, "stop float oe");
        chk(core_in, board & int_en & ICAP, "stop float in");
      end else begin
        chk(pad_oe, exp[15:0], "stop oe");
        chk(pad_out & exp[15:0], exp[31:16] & exp[15:0], "stop out");
      end
      chk(16'(usb_core_in), 16'(usb_in), "usb stop");
      chk(16'({main_osc_in_en, main_osc_out_high, sub_osc_in_en, sub_osc_out_high}),
          16'({mr, ~mr, ~mr & ~fs, mr & ~fs}), "osc");
      pulse(3);
    end
    serial_write_mode <= 1'b1;
    do_reset();
    pulse(0);
    pulse(1);
    settle();
    chk(pad_oe, '0, "serial oe");
    chk(core_in & ~(ANA | SUB), board & ~(ANA | SUB), "serial in");
    results();
  end

  // watchdog against a hung sequence
  initial begin
    step(20000);
    $display("[ERR] %0t watchdog expired", $time);
    failures++;
    results();
  end
endmodule // testbench
